// >>> verilog/flash_write_status_reporter.v
/*
  Host-side controller for a dual-bank parallel NOR flash: runs command
  sequences as bus writes, reads, and polls program/erase status bits.
  Assumes the flash pins are wired straight to the ports; data bus is
  two-way (in/out/enable), ready/busy input already pulled up outside.
*/
// Operation
// - Command cycles are writes except reads
// - Reset command leaves autoselect or timeout
// - Bypass program needs entry; exit sequence leaves
// - Suspend only during erase, with bank address
// - Recheck polling bit after timing limit; code rechecks toggle bit one (bit 6) instead, never the data polling bit
// - Status reads must address busy bank
`timescale 1ns/1ps
`include "flash_host_defs.vh"

module flash_write_status_reporter (
  input wire core_clk,
  input wire sys_rst,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [19:0] op_addr,
  input wire [15:0] op_data,
  output reg op_ready,
  output reg op_done,
  output reg op_fail,
  output reg [15:0] op_rdata,
  output reg [19:0] flash_addr,
  output reg [15:0] flash_dq_out,
  input wire [15:0] flash_dq_in,
  output reg flash_dq_oe,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n,
  input wire ready_busy_n
);

  localparam ST_IDLE = 3'd0;
  localparam ST_WSET = 3'd1;
  localparam ST_WLOW = 3'd2;
  localparam ST_WEND = 3'd3;
  localparam ST_RLOW = 3'd4;
  localparam ST_REND = 3'd5;

  reg [2:0] state_reg;
  reg [3:0] op_reg;
  reg [19:0] addr_reg;
  reg [15:0] data_reg;
  reg [2:0] step_reg;
  reg [2:0] cnt_reg;
  reg polling_reg;
  reg [7:0] prev_reg;
  reg first_read_reg;
  reg limit_seen_reg;

  // Cycle count of a sequence and the address/data of each write cycle
  reg [2:0] n_cycles;
  reg [19:0] cyc_addr;
  reg [15:0] cyc_data;
  reg cyc_is_read;
  always @* begin
    n_cycles = 3'd1;
    cyc_addr = `ADDR_UNLOCK1;
    cyc_data = {8'h00, `CMD_RESET};
    cyc_is_read = 1'b0;
    case (op_reg)
      `OP_READ: begin
        cyc_addr = addr_reg;
        cyc_is_read = 1'b1;
      end
      `OP_RESET: cyc_data = {8'h00, `CMD_RESET};
      `OP_SUSPEND: begin
        // Bank address carried in upper address bits
        cyc_addr = addr_reg;
        cyc_data = {8'h00, `CMD_ERASE_SUSPEND};
      end
      `OP_RESUME: begin
        cyc_addr = addr_reg;
        cyc_data = {8'h00, `CMD_ERASE_RESUME};
      end
      `OP_BYPASS_PROGRAM: begin
        n_cycles = 3'd2;
        cyc_addr = (step_reg == 3'd0) ? `ADDR_UNLOCK1 : addr_reg;
        cyc_data = (step_reg == 3'd0) ? {8'h00, `CMD_PROGRAM} : data_reg;
      end
      `OP_BYPASS_EXIT: begin
        n_cycles = 3'd2;
        cyc_data = (step_reg == 3'd0) ? {8'h00, `CMD_BYPASS_EXIT1} :
          {8'h00, `CMD_BYPASS_EXIT2};
      end
      default: begin
        // Unlocked sequences: AA, 55, then command; program/autoselect add an operand, sector erase adds AA, 55, 30
        n_cycles = 3'd3;
        if (op_reg == `OP_PROGRAM || op_reg == `OP_AUTOSELECT)
          n_cycles = 3'd4;
        if (op_reg == `OP_SECTOR_ERASE)
          n_cycles = 3'd6;
        case (step_reg)
          3'd0: cyc_data = {8'h00, `CMD_UNLOCK1};
          3'd1: begin
            cyc_addr = `ADDR_UNLOCK2;
            cyc_data = {8'h00, `CMD_UNLOCK2};
          end
          3'd2: begin
            // Bank bits of the target kept on the third cycle
            cyc_addr = {addr_reg[19:12], `ADDR_UNLOCK1_LOW};
            if (op_reg == `OP_PROGRAM) cyc_data = {8'h00, `CMD_PROGRAM};
            else if (op_reg == `OP_SECTOR_ERASE) cyc_data = {8'h00, `CMD_ERASE_SETUP};
            else if (op_reg == `OP_AUTOSELECT) cyc_data = {8'h00, `CMD_AUTOSELECT};
            else cyc_data = {8'h00, `CMD_BYPASS_ENTER};
          end
          3'd3: begin
            if (op_reg == `OP_SECTOR_ERASE) begin
              cyc_data = {8'h00, `CMD_UNLOCK1};
            end else begin
              // Program operand is full word; autoselect is a read
              cyc_addr = addr_reg;
              cyc_data = data_reg;
              cyc_is_read = (op_reg == `OP_AUTOSELECT);
            end
          end
          3'd4: begin
            cyc_addr = `ADDR_UNLOCK2;
            cyc_data = {8'h00, `CMD_UNLOCK2};
          end
          default: begin
            // Sector selected by bits 19..12
            cyc_addr = {addr_reg[`SECTOR_MSB:`SECTOR_LSB], 12'h000};
            cyc_data = {8'h00, `CMD_SECTOR_ERASE};
          end
        endcase
      end
    endcase
  end

  // Sequencer: write cycles, reads, then status polling
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      op_reg <= 4'h0;
      addr_reg <= 20'h0_0000;
      data_reg <= 16'h0000;
      step_reg <= 3'd0;
      cnt_reg <= 3'd0;
      polling_reg <= 1'b0;
      prev_reg <= 8'h00;
      first_read_reg <= 1'b0;
      limit_seen_reg <= 1'b0;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
      op_rdata <= 16'h0000;
      flash_addr <= 20'h0_0000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      op_done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          op_ready <= 1'b1;
          if (op_valid) begin
            op_ready <= 1'b0;
            op_reg <= op_code;
            addr_reg <= op_addr;
            data_reg <= op_data;
            step_reg <= 3'd0;
            polling_reg <= 1'b0;
            state_reg <= ST_WSET;
          end
        end
        ST_WSET: begin
          // Address driven on the same edge that chip select falls
          flash_addr <= polling_reg ? addr_reg : cyc_addr;
          flash_ce_n <= 1'b0;
          cnt_reg <= 3'd0;
          if (polling_reg || cyc_is_read) begin
            flash_oe_n <= 1'b0;
            state_reg <= ST_RLOW;
          end else begin
            flash_dq_out <= cyc_data;
            flash_dq_oe <= 1'b1;
            flash_we_n <= 1'b0;
            state_reg <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          cnt_reg <= cnt_reg + 3'd1;
          if (cnt_reg == `WR_PULSE_CYC - 1) begin
            // Write strobe rises first, data held across it
            flash_we_n <= 1'b1;
            state_reg <= ST_WEND;
          end
        end
        ST_WEND: begin
          flash_ce_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          step_reg <= step_reg + 3'd1;
          state_reg <= ST_WSET;
          if (step_reg == n_cycles - 3'd1) begin
            // Status valid after final strobe; poll program/erase
            first_read_reg <= 1'b1;
            limit_seen_reg <= 1'b0;
            if (op_reg == `OP_PROGRAM || op_reg == `OP_SECTOR_ERASE ||
                op_reg == `OP_BYPASS_PROGRAM)
              polling_reg <= 1'b1;
            else begin
              op_done <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RLOW: begin
          cnt_reg <= cnt_reg + 3'd1;
          if (cnt_reg == `RD_ACCESS_CYC - 1) begin
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            state_reg <= ST_REND;
            prev_reg <= flash_dq_in[7:0];
            first_read_reg <= 1'b0;
            if (!polling_reg) begin
              // Plain read or autoselect answer
              op_rdata <= flash_dq_in;
              op_done <= 1'b1;
            end else if (!first_read_reg &&
                flash_dq_in[`BIT_TOGGLE_ONE] == prev_reg[`BIT_TOGGLE_ONE]) begin
              // Toggle bit one stopped: done; this read gives whole word
              // Busy-bank address kept for every poll
              op_rdata <= flash_dq_in;
              op_fail <= 1'b0;
              op_done <= 1'b1;
              polling_reg <= 1'b0;
            end else if (limit_seen_reg) begin
              // Still toggling after limit flag and recheck: failed
              op_rdata <= flash_dq_in;
              op_fail <= 1'b1;
              op_done <= 1'b1;
              polling_reg <= 1'b0;
            end else if (!first_read_reg && flash_dq_in[`BIT_TIMING_LIMIT]) begin
              // Recheck once more before failing
              limit_seen_reg <= 1'b1;
            end
          end
        end
        ST_REND: begin
          // Each poll is a fresh chip-select read so toggle bits advance
          state_reg <= (polling_reg) ? ST_WSET : ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> verilog/flash_host_defs.vh
/*
  Constants for the flash host controller: command codes, unlock addresses,
  status bit positions and bus timing counts.
  Assumes a 25 MHz core clock and a word-wide parallel NOR flash.
*/
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

`define CLK_PERIOD_NS 40
// Write strobe low time and read access time, in ns
`define WR_PULSE_NS 80
`define RD_ACCESS_NS 120
`define WR_PULSE_CYC ((`WR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_ACCESS_CYC ((`RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Unlock addresses and command bytes (word mode)
`define ADDR_UNLOCK1 20'h0_0555
`define ADDR_UNLOCK2 20'h0_02AA
// Low twelve bits of the first unlock address, for bank-qualified cycles
`define ADDR_UNLOCK1_LOW 12'h555
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_RESET 8'hF0
`define CMD_ERASE_SUSPEND 8'hB0
`define CMD_ERASE_RESUME 8'h30
`define CMD_BYPASS_ENTER 8'h20
`define CMD_BYPASS_EXIT1 8'h90
`define CMD_BYPASS_EXIT2 8'h00
`define CMD_AUTOSELECT 8'h90

// Status bit positions on the data bus
`define BIT_DATA_POLLING 7
`define BIT_TOGGLE_ONE 6
`define BIT_TIMING_LIMIT 5
`define BIT_ERASE_TIMER 3
`define BIT_TOGGLE_TWO 2

// Sector field and autoselect answers
`define SECTOR_MSB 19
`define SECTOR_LSB 12
`define FACTORY_LOCKED 8'h81
`define SECTOR_PROTECTED 8'h01

// User operation codes
`define OP_READ 4'h0
`define OP_PROGRAM 4'h1
`define OP_SECTOR_ERASE 4'h2
`define OP_RESET 4'h3
`define OP_SUSPEND 4'h4
`define OP_RESUME 4'h5
`define OP_BYPASS_ENTER 4'h6
`define OP_BYPASS_PROGRAM 4'h7
`define OP_BYPASS_EXIT 4'h8
`define OP_AUTOSELECT 4'h9

`endif

// >>> sim/flash_model.sv
/* Behavioural word-mode flash answering the host controller's bus.
   Assumes the bus pins are wired straight to the controller. */
`timescale 1ns/1ps
module flash_model #(
  parameter int BUSY_READS = 3,
  parameter logic [19:0] FAIL_ADDR = 20'h0_3000
) (
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_wr,
  output logic [15:0] dq_rd,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic ready_busy_n
);
  logic [15:0] mem [int];
  logic [15:0] rd_word = 16'h0000;
  logic [15:0] hold = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic [19:0] la = 20'h0_0000;
  int cyc = 0;
  int busy = 0;
  bit tog, stuck, asel, byp, bx, pnext;
  wire wr = !we_n && !ce_n;
  // Address taken when the later strobe falls
  always @(posedge wr) la = addr;
  // Data taken when the earlier strobe rises, then decoded
  always @(negedge wr) begin
    logic [7:0] d;
    d = dq_wr[7:0];
    if (pnext) begin
      pnext = 0;
      pd = dq_wr;
      busy = BUSY_READS;
      if (la == FAIL_ADDR) stuck = 1;
      else mem[la] = dq_wr;
    end else if (d == 8'hF0) begin
      asel = 0;
      stuck = 0;
      cyc = 0;
    end else if (byp && d == 8'hA0) pnext = 1;
    else if (byp && d == 8'h90) bx = 1;
    else if (bx && d == 8'h00) begin
      byp = 0;
      bx = 0;
    end else if (cyc == 0 && d == 8'hAA && la[10:0] == 11'h555) cyc = 1;
    else if (cyc == 1 && d == 8'h55 && la[10:0] == 11'h2AA) cyc = 2;
    else if (cyc == 2) begin
      cyc = 0;
      pnext = d == 8'hA0;
      byp = d == 8'h20;
      asel = d == 8'h90;
    end
  end
  // Read word chosen once the read cycle opens
  always @(negedge oe_n) begin
    #1;
    if (busy > 0 || stuck)
      rd_word = {8'h00, ~pd[7], tog, stuck, 5'h00};
    else if (asel)
      rd_word = (addr[7:0] == 8'h02) ? 16'h0001 : 16'h0081;
    else
      rd_word = mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end
  // Toggle and progress advance per read cycle
  always @(posedge oe_n) begin
    hold = dq_rd;
    if (busy > 0 || stuck) tog = !tog;
    if (busy > 0) busy = busy - 1;
  end
  // Released bus shows the inverse of the last word
  assign dq_rd = (!oe_n && !ce_n) ? rd_word : ~hold;
  assign ready_busy_n = !(busy > 0);
endmodule

// >>> sim/flash_write_status_reporter_chk.sv
/* Port checker for the flash host controller.
   Bound to every instance of the controller by name. */
`timescale 1ns/1ps
module flash_write_status_reporter_chk (
  input wire core_clk,
  input wire sys_rst,
  input wire op_valid,
  input wire op_ready,
  input wire op_done,
  input wire [19:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire flash_ce_n,
  input wire flash_we_n,
  input wire flash_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Bus cycle shape
  property p_wr_dir; !flash_we_n |-> flash_dq_oe && flash_oe_n; endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("write without drive");
  property p_rd_dir; !flash_oe_n |-> !flash_dq_oe && flash_we_n; endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read while driving");
  property p_wr_ce; $fell(flash_we_n) |-> !flash_ce_n; endproperty
  a_wr_ce: assert property (p_wr_ce) else $error("write without select");
  property p_wr_hold; !flash_we_n ##1 !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write bus moved");
  property p_wr_len; $fell(flash_we_n) |-> ##[1:4] $rose(flash_we_n); endproperty
  a_wr_len: assert property (p_wr_len) else $error("write pulse length");
  property p_dat_hold; $rose(flash_we_n) |-> flash_dq_oe; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("data hold lost");
  // User handshake
  property p_done; op_done |=> !op_done; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_take; op_valid && op_ready |=> !op_ready; endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_rst; disable iff (1'b0) sys_rst |=> !op_ready && flash_we_n && flash_ce_n && !flash_dq_oe; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_done: cover property (op_done);
  c_read: cover property ($fell(flash_oe_n));
  c_write: cover property ($fell(flash_we_n));
endmodule
bind flash_write_status_reporter flash_write_status_reporter_chk i_flash_write_status_reporter_chk (.*);

// >>> sim/test_flash_write_status_reporter.sv
/* Self-checking bench for the flash host controller.
   Orders go in at falling clock edges; the flash model answers. */
`timescale 1ns/1ps
`include "flash_host_defs.vh"
module test_flash_write_status_reporter;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic op_valid = 0;
  logic [3:0] op_code = 4'h0;
  logic [19:0] op_addr = 20'h0_0000;
  logic [15:0] op_data = 16'h0000;
  wire op_ready, op_done, op_fail, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, ready_busy_n;
  wire [15:0] op_rdata, flash_dq_out, flash_dq_in;
  wire [19:0] flash_addr;
  int err_count = 0;
  int checks = 0;
  flash_write_status_reporter i_flash_write_status_reporter (.*);
  flash_model i_flash_model (.addr(flash_addr), .dq_wr(flash_dq_out), .dq_rd(flash_dq_in),
    .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .ready_busy_n(ready_busy_n));
  // 25 MHz clock
  initial forever #20 core_clk = ~core_clk;
  task automatic stop_test;
    $display("Counts: %0d mismatches, %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One order, waited for under a bound
  task automatic do_op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
    int n;
    op_code = c;
    op_addr = a;
    op_data = d;
    op_valid = 1;
    n = 0;
    // Ready is looked at between edges; the request then stands across one rising edge
    while (op_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    op_valid = 0;
    while (op_done !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      $display("MISMATCH %0t order timed out", $time);
      stop_test;
    end else begin
      @(negedge core_clk);
    end
  endtask
  // Erase of one sector, then suspend and resume at that bank
  task automatic t_erase;
    do_op(`OP_SECTOR_ERASE, 20'h0_5000, 16'h0000);
    chk({15'h0000, op_fail}, 16'h0000, "erase flag");
    do_op(`OP_SUSPEND, 20'h0_5000, 16'h0000);
    chk({15'h0000, op_fail}, 16'h0000, "suspend flag");
    do_op(`OP_RESUME, 20'h0_5000, 16'h0000);
    chk({15'h0000, op_fail}, 16'h0000, "resume flag");
  endtask
  task automatic t_program;
    do_op(`OP_PROGRAM, 20'h0_1000, 16'h1234);
    chk({15'h0000, op_fail}, 16'h0000, "program flag");
    do_op(`OP_READ, 20'h0_1000, 16'h0000);
    chk(op_rdata, 16'h1234, "program word");
  endtask
  task automatic t_bypass;
    do_op(`OP_BYPASS_ENTER, 20'h0_2000, 16'h0000);
    do_op(`OP_BYPASS_PROGRAM, 20'h0_2000, 16'hABCD);
    do_op(`OP_BYPASS_EXIT, 20'h0_2000, 16'h0000);
    do_op(`OP_READ, 20'h0_2000, 16'h0000);
    chk(op_rdata, 16'hABCD, "bypass word");
  endtask
  task automatic t_query;
    do_op(`OP_AUTOSELECT, 20'h0_1002, 16'h0000);
    chk({8'h00, op_rdata[7:0]}, 16'h0001, "protect query");
    do_op(`OP_AUTOSELECT, 20'h0_0003, 16'h0000);
    chk({8'h00, op_rdata[7:0]}, 16'h0081, "lock query");
    do_op(`OP_RESET, 20'h0_0000, 16'h0000);
    do_op(`OP_READ, 20'h0_1000, 16'h0000);
    chk(op_rdata, 16'h1234, "array after query");
  endtask
  // Model fails programs at 20'h0_3000
  task automatic t_fail;
    do_op(`OP_PROGRAM, 20'h0_3000, 16'h5555);
    chk({15'h0000, op_fail}, 16'h0001, "failed program");
    do_op(`OP_RESET, 20'h0_0000, 16'h0000);
    do_op(`OP_READ, 20'h0_2000, 16'h0000);
    chk(op_rdata, 16'hABCD, "array after fail");
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (12) @(negedge core_clk);
    sys_rst = 0;
    @(negedge core_clk);
    t_program;
    t_bypass;
    t_query;
    t_fail;
    t_erase;
    stop_test;
  end
endmodule
